// ---- hw/mrpa_top.sv ----
// repeater port arbiter with shared nibble path and status trains
`timescale 1ns/1ns

// ************************************************************
// elasticity fifo between receive and transmit sides
// ************************************************************
module mrpa_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // flush at frame end
   input wire logic flush
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];               // storage words
   logic [AW-1:0] wr_ff;                           // write index
   logic [AW-1:0] rd_ff;                           // read index
   logic [AW:0] cnt_ff;                            // words held
   logic push;
   logic pop;
   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));   // honest full
   assign out_valid = (cnt_ff != '0);              // honest empty
   assign out_data = mem_ff[rd_ff];
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;
   // storage write
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
   // indices and count
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else if (flush) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop) rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // mrpa_fifo

// ************************************************************
// arbiter top
// ************************************************************
module mrpa_top #(
   parameter longint JABBER_LIMIT = mrpa_pkg::JABBER_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // per-port phy signals
   input wire logic [mrpa_pkg::NUM_PORTS-1:0] crs,
   input wire logic [mrpa_pkg::NUM_PORTS-1:0] link,
   input wire logic [mrpa_pkg::NUM_PORTS-1:0] rx_clk_port,
   output logic [mrpa_pkg::NUM_PORTS-1:0] receive_grant,
   output logic [mrpa_pkg::NUM_PORTS-1:0] tx_en,
   // shared receive bus
   input wire logic [mrpa_pkg::NIB_W-1:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   // shared transmit bus
   input wire logic transmit_reference_clock,
   output logic [mrpa_pkg::NIB_W-1:0] txd,
   output logic tx_er,
   // status report
   output logic [mrpa_pkg::NUM_PORTS-1:0] port_status_report_pins_n,
   output logic [mrpa_pkg::ITEMS-1:0] status_strobe
);
   localparam int NP = mrpa_pkg::NUM_PORTS;
   localparam int SW = 3 * NP + mrpa_pkg::NIB_W + 3; // synchronised bits

   // how many carriers are up
   function automatic logic [3:0] ones(input logic [NP-1:0] v);
      logic [3:0] n;
      n = '0;
      for (int i = 0; i < NP; i++) n = n + 4'(v[i]);
      return n;
   endfunction

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [SW-1:0] meta_ff;                         // first stage, read by second only
   logic [SW-1:0] sync_ff;                         // second stage
   logic [NP-1:0] grant_ff;
   // two flops per outside input
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {crs, link, rx_clk_port, rxd, rx_dv, rx_er, transmit_reference_clock};
         sync_ff <= meta_ff;
      end
   end
   logic [NP-1:0] crs_s;
   logic [NP-1:0] link_s;
   logic [NP-1:0] rxc_port_s;                      // every receive clock, synchronised
   logic [mrpa_pkg::NIB_W-1:0] rxd_s;
   logic dv_s;
   logic er_s;
   logic rxc_s;                                    // receive clock of granted port
   logic txc_s;
   assign {crs_s, link_s, rxc_port_s, rxd_s, dv_s, er_s, txc_s} = sync_ff;
   // select after the flops so no raw pin meets logic before synchronising
   assign rxc_s = |(rxc_port_s & grant_ff);
   // edge finders on synchronised clocks
   logic rxc_d_ff;
   logic txc_d_ff;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxc_d_ff <= 1'b0;
         txc_d_ff <= 1'b0;
      end else begin
         rxc_d_ff <= rxc_s;
         txc_d_ff <= txc_s;
      end
   end
   logic rxc_rise;
   logic txc_rise;
   assign rxc_rise = rxc_s && !rxc_d_ff;
   assign txc_rise = txc_s && !txc_d_ff;

   // ************************************************************
   // arbiter
   // ************************************************************
   mrpa_pkg::mrpa_arb_e state_ff;
   mrpa_pkg::mrpa_arb_e nxt_state;
   logic [3:0] n_crs;
   assign n_crs = ones(crs_s);
   // next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mrpa_pkg::ARB_IDLE: begin
            if (n_crs == 4'h1) nxt_state = mrpa_pkg::ARB_RECV;
            else if (n_crs > 4'h1) nxt_state = mrpa_pkg::ARB_COLL;
         end
         mrpa_pkg::ARB_RECV: begin
            if (n_crs == 4'h0) nxt_state = mrpa_pkg::ARB_IDLE;
            else if ((crs_s & ~grant_ff) != '0) nxt_state = mrpa_pkg::ARB_COLL;
         end
         mrpa_pkg::ARB_COLL: begin
            if (n_crs == 4'h0) nxt_state = mrpa_pkg::ARB_IDLE;
         end
         default: nxt_state = mrpa_pkg::ARB_IDLE;
      endcase
   end
   // state, grant and transmit enables
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= mrpa_pkg::ARB_IDLE;
         grant_ff <= '0;
         tx_en <= '0;
      end else begin
         state_ff <= nxt_state;
         case (nxt_state)
            mrpa_pkg::ARB_RECV: begin
               // keep the port that was alone when granted
               if (state_ff == mrpa_pkg::ARB_IDLE) grant_ff <= crs_s;
               tx_en <= (state_ff == mrpa_pkg::ARB_IDLE) ? ~crs_s : ~grant_ff;
            end
            mrpa_pkg::ARB_COLL: begin
               grant_ff <= '0;
               tx_en <= '1;
            end
            default: begin
               grant_ff <= '0;
               tx_en <= '0;
            end
         endcase
      end
   end
   assign receive_grant = grant_ff;

   // ************************************************************
   // data path
   // ************************************************************
   logic f_in_ready;
   logic f_out_valid;
   logic [mrpa_pkg::FIFO_W-1:0] f_out_data;
   logic f_push;
   logic f_flush;
   logic fifo_err_ff;                              // overflow or mid-frame underflow
   logic frame_ff;                                 // transmit side is streaming
   // nibble taken on the selected receive clock rise while data valid
   assign f_push = rxc_rise && dv_s && (state_ff == mrpa_pkg::ARB_RECV);
   assign f_flush = (state_ff == mrpa_pkg::ARB_IDLE) && !f_out_valid && !frame_ff;
   mrpa_fifo #(
      .WIDTH(mrpa_pkg::FIFO_W),
      .DEPTH(mrpa_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data({er_s, rxd_s}),
      .out_valid(f_out_valid),
      .out_ready(txc_rise),
      .out_data(f_out_data),
      .flush(f_flush)
   );
   // fifo error: push refused when full, or starved mid-frame
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fifo_err_ff <= 1'b0;
      end else if ((f_push && !f_in_ready) || (txc_rise && frame_ff && !f_out_valid
                   && state_ff == mrpa_pkg::ARB_RECV)) begin
         fifo_err_ff <= 1'b1;
      end else if (state_ff == mrpa_pkg::ARB_IDLE) begin
         fifo_err_ff <= 1'b0;
      end
   end
   // transmit nibble moves only on reference clock rise
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txd <= '0;
         tx_er <= 1'b0;
         frame_ff <= 1'b0;
      end else if (txc_rise) begin
         frame_ff <= f_out_valid;
         txd <= f_out_valid ? f_out_data[mrpa_pkg::NIB_W-1:0] : '0;
         tx_er <= (f_out_valid && f_out_data[mrpa_pkg::NIB_W]) || fifo_err_ff;
      end
   end

   // ************************************************************
   // port status: jabber, partition (utilization is picked in the status train)
   // ************************************************************
   logic [39:0] jab_cnt_ff;                        // carrier length of granted port
   logic [NP-1:0] jab_ff;
   logic [NP-1:0] part_ff;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         jab_cnt_ff <= '0;
      end else if (state_ff == mrpa_pkg::ARB_RECV) begin
         if (jab_cnt_ff != 40'(JABBER_LIMIT)) jab_cnt_ff <= jab_cnt_ff + 40'h1;
      end else begin
         jab_cnt_ff <= '0;
      end
   end
   // jabber sticks until carrier drops; set wins over clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         jab_ff <= '0;
      end else begin
         jab_ff <= (jab_ff & crs_s) |
                   ((jab_cnt_ff == 40'(JABBER_LIMIT)) ? grant_ff : '0);
      end
   end
   // partition marks collision members until a clean receive
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         part_ff <= '0;
      end else begin
         part_ff <= (part_ff & ~grant_ff) |
                    ((state_ff == mrpa_pkg::ARB_COLL) ? crs_s : '0);
      end
   end

   // ************************************************************
   // status train
   // ************************************************************
   logic [15:0] div_ff;
   logic [1:0] item_ff;
   logic [NP-1:0] item_val;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_ff <= '0;
         item_ff <= mrpa_pkg::ITEM_LINK;
      end else if (div_ff == 16'(mrpa_pkg::STATUS_ITEM_CYC - 1)) begin
         div_ff <= '0;
         item_ff <= item_ff + 2'h1;
      end else begin
         div_ff <= div_ff + 16'h1;
      end
   end
   // pick the item for every port
   always_comb begin
      case (item_ff)
         mrpa_pkg::ITEM_LINK: item_val = link_s;
         mrpa_pkg::ITEM_PART: item_val = part_ff;
         mrpa_pkg::ITEM_UTIL: item_val = (n_crs != 4'h0) ? '1 : '0;
         default: item_val = jab_ff;
      endcase
   end
   // active-low train and the strobe naming the item
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port_status_report_pins_n <= '1;
         status_strobe <= '0;
      end else begin
         port_status_report_pins_n <= ~item_val;
         status_strobe <= 4'h1 << item_ff;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_one_grant;
      @(posedge sys_clk) disable iff (!resetn) $onehot0(receive_grant);
   endproperty
   a_one_grant: assert property (p_one_grant) else $error("two grants");
   property p_grant_alone;
      @(posedge sys_clk) disable iff (!resetn)
         (receive_grant != '0) |-> ($past(crs_s) & receive_grant) == receive_grant;
   endproperty
   a_grant_alone: assert property (p_grant_alone) else $error("grant without carrier");
   property p_answer;
      @(posedge sys_clk) disable iff (!resetn)
         (state_ff == mrpa_pkg::ARB_IDLE && n_crs == 4'h1) |=> (receive_grant == $past(crs_s));
   endproperty
   a_answer: assert property (p_answer) else $error("carrier not answered");
   property p_tx_others;
      @(posedge sys_clk) disable iff (!resetn)
         (receive_grant != '0) |-> (tx_en == ~receive_grant);
   endproperty
   a_tx_others: assert property (p_tx_others) else $error("tx enable wrong");
   property p_drop;
      @(posedge sys_clk) disable iff (!resetn)
         (state_ff != mrpa_pkg::ARB_IDLE && n_crs == 4'h0) |=>
            (receive_grant == '0 && tx_en == '0 && state_ff == mrpa_pkg::ARB_IDLE);
   endproperty
   a_drop: assert property (p_drop) else $error("enables held after carrier");
   property p_coll;
      @(posedge sys_clk) disable iff (!resetn)
         (n_crs > 4'h1) |=> (receive_grant == '0 && tx_en == '1);
   endproperty
   a_coll: assert property (p_coll) else $error("collision granted");
   property p_txd_step;
      @(posedge sys_clk) disable iff (!resetn)
         !$past(txc_rise) |-> $stable(txd);
   endproperty
   a_txd_step: assert property (p_txd_step) else $error("txd off clock");
   property p_tx_er;
      @(posedge sys_clk) disable iff (!resetn)
         (txc_rise && fifo_err_ff) |=> tx_er;
   endproperty
   a_tx_er: assert property (p_tx_er) else $error("fifo error lost");
   property p_push_rx;
      @(posedge sys_clk) disable iff (!resetn)
         f_push |-> $onehot(receive_grant) && rxc_rise;
   endproperty
   a_push_rx: assert property (p_push_rx) else $error("nibble off receive clock");
   property p_link_item;
      @(posedge sys_clk) disable iff (!resetn)
         (item_ff == mrpa_pkg::ITEM_LINK) |=> (port_status_report_pins_n == ~$past(link_s));
   endproperty
   a_link_item: assert property (p_link_item) else $error("link item wrong");
endmodule // mrpa_top

// ---- hw/mrpa_pkg.sv ----
// constants and types for the repeater port arbiter
// How it works
// - carrier on a port answers with its grant
// - grant only when that carrier alone is present
// - at most one receive grant at once
// - carrier enables transmit on all other ports
// - one transmit enable per port, ten down to zero
// - granted port selects receive clock used
// - receive nibble taken on receive clock rise
// - transmit nibble changes on reference clock rise
// - receive error marks bad received data
// - transmit error on receive or fifo error
// - link status merged into per-port status train
// - shared bus serves up to eleven phys
// - train sends link, partition, utilization, jabber
package mrpa_pkg;
   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NUM_PORTS = 11;                  // phys on the shared bus
   localparam int NIB_W = 4;                       // data nibble width
   localparam int FIFO_W = NIB_W + 1;              // nibble plus error flag
   localparam int FIFO_DEPTH = 32;                 // elasticity words
   localparam int ITEMS = 4;                       // status items per train
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS = 4;                      // sys_clk period
   localparam int STATUS_ITEM_NS = 1000;           // time each status item stands
   localparam int STATUS_ITEM_CYC = STATUS_ITEM_NS / CLK_NS;
   localparam longint JABBER_US = 5000;            // carrier length called jabber
   localparam longint JABBER_CYC = (JABBER_US * 64'd1000) / CLK_NS;
   // ************************************************************
   // status item order in the train
   // ************************************************************
   localparam logic [1:0] ITEM_LINK = 2'h0;        // link status
   localparam logic [1:0] ITEM_PART = 2'h1;        // partition
   localparam logic [1:0] ITEM_UTIL = 2'h2;        // utilization
   localparam logic [1:0] ITEM_JAB = 2'h3;         // jabber
   // arbiter states
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_RECV = 2'b01,
      ARB_COLL = 2'b10
   } mrpa_arb_e;
endpackage

// ---- tb/mrpa_phy_model.sv ----
// behavioural model of the eleven phys on the shared receive bus
`timescale 1ns/1ns
module mrpa_phy_model (
   // pacing clock
   input wire logic sys_clk,
   // per-port phy signals
   output logic [10:0] crs,
   output logic [10:0] link,
   output logic [10:0] rx_clk_port,
   // shared receive bus
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic rx_er
);
   // quiet bus, no carrier, no link, clocks standing still
   initial begin
      crs = 11'h000;
      link = 11'h000;
      rx_clk_port = 11'h000;
      rxd = 4'h0;
      rx_dv = 1'b0;
      rx_er = 1'b0;
   end
   // each port drives its own carrier line
   task automatic set_crs(input int p, input bit v);
      crs[p] = v;
   endtask
   // link status of all ports
   task automatic set_link(input logic [10:0] v);
      link = v;
   endtask
   // one half period of a 25 MHz receive clock
   task automatic half(input int p);
      repeat (5) @(negedge sys_clk);
      rx_clk_port[p] = ~rx_clk_port[p];
   endtask
   // one frame of n nibbles; clock runs only inside the frame
   task automatic send(input int p, input int n, input int first, input int err_at,
                       input bit drop);
      crs[p] = 1'b1;
      repeat (4) half(p);
      for (int k = 0; k < n; k++) begin
         rxd = 4'((first + k) % 15 + 1);
         rx_dv = 1'b1;
         rx_er = (k == err_at);
         repeat (2) half(p);
      end
      rx_dv = 1'b0;
      rx_er = 1'b0;
      // released bus must not keep the last nibble
      rxd = ~rxd;
      repeat (2) half(p);
      if (drop) begin
         crs[p] = 1'b0;
      end
   endtask
endmodule // mrpa_phy_model

// ---- tb/mrpa_top_tb.sv ----
// self-checking bench for the repeater port arbiter
`timescale 1ns/1ns
module mrpa_top_tb;
   // ************************************************************
   // signals
   // ************************************************************
   logic sys_clk;
   logic resetn;
   logic txc; // transmit reference clock
   logic tx_run; // low stalls the transmit side
   logic [10:0] crs, link, rx_clk_port, receive_grant, tx_en, report_n;
   logic [3:0] rxd, txd, status_strobe;
   logic rx_dv, rx_er, tx_er;
   logic [4:0] got[$]; // {tx_er, txd} per non-empty transmit slot
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   // ************************************************************
   // clocks, design and phys
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // 160 ns transmit clock, phase unrelated to sys_clk
   initial begin
      txc = 1'b0;
      #37;
      forever begin
         #80;
         txc = tx_run ? ~txc : 1'b0;
      end
   end
   mrpa_top #(.JABBER_LIMIT(200)) i_dut (
      .sys_clk(sys_clk), .resetn(resetn), .crs(crs), .link(link),
      .rx_clk_port(rx_clk_port), .receive_grant(receive_grant), .tx_en(tx_en),
      .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .transmit_reference_clock(txc),
      .txd(txd), .tx_er(tx_er), .port_status_report_pins_n(report_n),
      .status_strobe(status_strobe));
   mrpa_phy_model i_phy (
      .sys_clk(sys_clk), .crs(crs), .link(link), .rx_clk_port(rx_clk_port),
      .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er));
   // ************************************************************
   // compare and helper tasks
   // ************************************************************
   task automatic chk11(input string what, input logic [10:0] exp, input logic [10:0] act);
      tests_run++;
      if (act !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, act);
      end
   endtask
   task automatic chk5(input string what, input logic [4:0] exp, input logic [4:0] act);
      tests_run++;
      if (act !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, act);
      end
   endtask
   // wait a bounded time for a status item, then check it
   task automatic wait_strobe(input logic [3:0] exp, input int lim);
      for (int i = 0; i < lim && status_strobe !== exp; i++) @(negedge sys_clk);
      chk11("strobe", 11'(exp), 11'(status_strobe));
   endtask
   // record the transmit word shortly after each transmit clock rise
   task automatic collect(input int n);
      got = {};
      repeat (n) begin
         @(posedge txc);
         repeat (6) @(negedge sys_clk);
         if (txd !== 4'h0) got.push_back({tx_er, txd});
      end
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   // every port granted alone, then everything released
   task automatic t_single;
      for (int p = 0; p < 11; p++) begin
         i_phy.set_crs(p, 1'b1);
         repeat (3) @(negedge sys_clk);
         chk11("grant", 11'h001 << p, receive_grant);
         chk11("tx_en", ~(11'h001 << p), tx_en);
         i_phy.set_crs(p, 1'b0);
         repeat (3) @(negedge sys_clk);
         chk11("grant off", 11'h000, receive_grant);
         chk11("tx_en off", 11'h000, tx_en);
      end
   endtask
   // second carrier during receive, then two carriers from idle
   task automatic t_collision;
      i_phy.set_crs(2, 1'b1);
      repeat (4) @(negedge sys_clk);
      i_phy.set_crs(5, 1'b1);
      repeat (3) @(negedge sys_clk);
      chk11("coll grant", 11'h000, receive_grant);
      chk11("coll tx_en", 11'h7ff, tx_en);
      i_phy.set_crs(2, 1'b0);
      repeat (6) @(negedge sys_clk);
      chk11("lone grant", 11'h000, receive_grant);
      i_phy.set_crs(5, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk11("end tx_en", 11'h000, tx_en);
      i_phy.set_crs(7, 1'b1);
      i_phy.set_crs(9, 1'b1);
      repeat (3) @(negedge sys_clk);
      chk11("dual grant", 11'h000, receive_grant);
      chk11("dual tx_en", 11'h7ff, tx_en);
      i_phy.set_crs(7, 1'b0);
      i_phy.set_crs(9, 1'b0);
      repeat (4) @(negedge sys_clk);
   endtask
   // one full status train with link, collision history, carrier and jabber
   task automatic t_status;
      i_phy.set_link(11'h5a3);
      i_phy.set_crs(4, 1'b1);
      wait_strobe(4'h8, 1100);
      wait_strobe(4'h1, 260);
      chk11("link item", ~11'h5a3, report_n);
      wait_strobe(4'h2, 260);
      chk11("partition", 11'h000, report_n & 11'h2a0);
      wait_strobe(4'h4, 260);
      chk11("utilization", 11'h000, report_n);
      wait_strobe(4'h8, 260);
      chk11("jabber", 11'h000, report_n & 11'h010);
      i_phy.set_crs(4, 1'b0);
      repeat (4) @(negedge sys_clk);
   endtask
   // clean frame with one bad nibble, transmit side running
   task automatic t_stream;
      fork
         i_phy.send(3, 8, 0, 2, 1'b1);
         collect(16);
      join
      chk11("count", 11'd8, 11'(got.size()));
      for (int k = 0; k < 8 && k < got.size(); k++) begin
         chk5("nibble", 5'(k + 1), {1'b0, got[k][3:0]});
      end
      if (got.size() > 2) chk5("bad word", 5'h13, got[2]);
   endtask
   // transmit stalled: fill past 32 words, then drain while receiving
   task automatic t_overfill;
      logic er;
      er = 1'b0;
      tx_run = 1'b0;
      i_phy.send(6, 40, 3, -1, 1'b0);
      tx_run = 1'b1;
      collect(36);
      i_phy.set_crs(6, 1'b0);
      chk11("kept", 11'd32, 11'(got.size()));
      for (int k = 0; k < got.size(); k++) begin
         er = er | got[k][4];
         if (k < 32) chk5("kept nibble", 5'((3 + k) % 15 + 1), {1'b0, got[k][3:0]});
      end
      chk5("fifo error", 5'h10, {er, 4'h0});
      repeat (8) @(negedge sys_clk);
   endtask
   // ************************************************************
   // run control
   // ************************************************************
   task automatic give_verdict;
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         give_verdict;
      end
   end
   // reset, then every scenario in turn
   initial begin
      resetn = 1'b0;
      tx_run = 1'b1;
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_single;
      t_collision;
      t_status;
      t_stream;
      t_overfill;
      give_verdict;
   end
endmodule // mrpa_top_tb
